// File: verilog/litm_pkg.sv
// Package with register map, field layout and timing constants of the interrupt pacer.
// ---------------------------------------------------------------------------
// Overview of operation
// - The pacing register holds a 16-bit minimum gap in its low half in 256 ns units and its upper half reads as zero.
// - A gap of zero bypasses pacing so interrupts appear without enforced spacing.
// - With a nonzero gap no new interrupt is asserted sooner than the gap after the previous one.
// - In 10/100 quarter-clock operation the effective gap is four times the programmed value.
// - Writing one to a cause force bit sets that cause as if the event occurred; zeros change nothing.
// - Cause and enable bits sit at positions 0,1,2,4,5,6,7,9,12,13,14,15,16,17,18 and 22.
// - Bits 3, 8, 11:10, 21:19 and 31:23 are reserved and read only; software writes zero above.
// - Reading the enable set register returns the enable state of each source, all clear after reset.
// - Writing one to an enable set bit enables that source; zeros keep the old state.
// - The interrupt is raised when any source has both its enable bit and its cause bit set.
// - With timer clear enabled, writing all ones to the enable set register restarts all interrupt timers.
// - Writing one to an enable clear bit clears that enable; zeros leave it.
// - Writing one to a cause read bit clears that cause; the summary bit clears once no enabled cause remains.
// ---------------------------------------------------------------------------
package litm_pkg;
    // -----------------------------------------------------------------------
    // Register byte offsets
    // -----------------------------------------------------------------------
    localparam logic [11:0] LITM_PACING_OFF = 12'h0c4;
    localparam logic [11:0] LITM_FORCE_OFF = 12'h0c8;
    localparam logic [11:0] LITM_CAUSE_OFF = 12'h0c0;
    localparam logic [11:0] LITM_ENSET_OFF = 12'h0d0;
    localparam logic [11:0] LITM_ENCLR_OFF = 12'h0d8;
    localparam logic [11:0] LITM_EXTCTL_OFF = 12'h018;
    // -----------------------------------------------------------------------
    // Field layout and reset values
    // -----------------------------------------------------------------------
    localparam logic [31:0] LITM_SRC_MASK = 32'h0047_f2f7;
    localparam int LITM_SUMMARY_BIT = 31;
    localparam int LITM_TCLR_BIT = 0;
    localparam int LITM_SLOW_BIT = 1;
    localparam logic [31:0] LITM_ALL_ONES = 32'hffff_ffff;
    localparam logic [15:0] LITM_PACING_RST = 16'h0000;
    localparam logic [31:0] LITM_ZERO32 = 32'h0000_0000;
    // -----------------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------------
    localparam int LITM_UNIT_NS = 256;
    localparam int LITM_CLK_NS = 40;
    localparam int LITM_UNIT_CYC = (LITM_UNIT_NS + LITM_CLK_NS - 1) / LITM_CLK_NS;
    localparam int LITM_SLOW_FACTOR = 4;
    localparam logic [7:0] LITM_UNIT_CYC8 = 8'(LITM_UNIT_CYC);
endpackage : litm_pkg

// File: verilog/litm_tick.sv
// Unit tick generator producing one pulse per 256 ns pacing unit.
`timescale 1ns/1ps
module litm_tick
    import litm_pkg::*;
#(
    parameter int UNIT_CYC = LITM_UNIT_CYC
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Control.
    input wire logic restart,
    input wire logic slow,
    output logic tick
);
    localparam logic [9:0] SLOW_CYC = 10'(UNIT_CYC * LITM_SLOW_FACTOR);
    localparam logic [9:0] FAST_CYC = 10'(UNIT_CYC);

    initial begin
        if (UNIT_CYC < 1 || UNIT_CYC > 255) begin
            $error("litm_tick: unit count out of range.");
        end
    end

    logic [9:0] cnt_q;
    logic [9:0] limit;

    // The unit stretches fourfold in quarter-clock operation.
    assign limit = slow ? SLOW_CYC : FAST_CYC;

    // Count cycles of one unit and pulse at its end.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 10'h000;
            tick <= 1'b0;
        end else if (clk_en) begin
            if (restart) begin
                cnt_q <= 10'h000;
                tick <= 1'b0;
            end else if (cnt_q + 10'h001 >= limit) begin
                cnt_q <= 10'h000;
                tick <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 10'h001;
                tick <= 1'b0;
            end
        end
    end
endmodule : litm_tick

// File: verilog/litm_top.sv
// Interrupt pacing and enable logic with an APB register slave.
`timescale 1ns/1ps
module litm_top
    import litm_pkg::*;
#(
    parameter int GAP_W = 16
) (
    // Clock, enable and reset.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Hardware interrupt events, one-cycle pulses from logic on pclk.
    input wire logic [31:0] cause_event,
    // Interrupt toward the host.
    output logic irq
);
    initial begin
        if (GAP_W != 16) begin
            $error("litm_top: gap width must be 16.");
        end
    end

    // -----------------------------------------------------------------------
    // Bus decode
    // -----------------------------------------------------------------------
    logic acc;
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] wmask;
    assign acc = psel && penable && !pready;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;

    // Expand byte strobes to a bit mask.
    function automatic logic [31:0] litm_strb(input logic [3:0] s);
        litm_strb = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : litm_strb

    // Decide whether an address is mapped.
    function automatic logic litm_mapped(input logic [11:0] a);
        litm_mapped = (a == LITM_PACING_OFF) || (a == LITM_FORCE_OFF) ||
                      (a == LITM_CAUSE_OFF) || (a == LITM_ENSET_OFF) ||
                      (a == LITM_ENCLR_OFF) || (a == LITM_EXTCTL_OFF);
    endfunction : litm_mapped

    assign wmask = litm_strb(pstrb);
    assign hit = litm_mapped(paddr);

    logic wr_pace;
    logic wr_force;
    logic wr_cause;
    logic wr_enset;
    logic wr_enclr;
    logic wr_ext;
    logic rd_cause;
    logic [31:0] wsrc;
    assign wr_pace = wr && paddr == LITM_PACING_OFF;
    assign wr_force = wr && paddr == LITM_FORCE_OFF;
    assign wr_cause = wr && paddr == LITM_CAUSE_OFF;
    assign wr_enset = wr && paddr == LITM_ENSET_OFF;
    assign wr_enclr = wr && paddr == LITM_ENCLR_OFF;
    assign wr_ext = wr && paddr == LITM_EXTCTL_OFF;
    assign rd_cause = rd && paddr == LITM_CAUSE_OFF;
    assign wsrc = pwdata & wmask & LITM_SRC_MASK;

    // -----------------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------------
    logic [15:0] gap_q;
    logic [31:0] cause_q;
    logic [31:0] cause_d;
    logic [31:0] enable_q;
    logic [31:0] enable_d;
    logic tclr_en_q;
    logic slow_q;
    logic timer_restart;

    // Pacing register holds the gap in the low half only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= LITM_PACING_RST;
        end else if (clk_en && wr_pace) begin
            gap_q <= (pwdata[15:0] & wmask[15:0]) | (gap_q & ~wmask[15:0]);
        end
    end

    // Extended control holds timer clear enable and quarter-clock mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tclr_en_q <= 1'b0;
            slow_q <= 1'b0;
        end else if (clk_en && wr_ext && pstrb[0]) begin
            tclr_en_q <= pwdata[LITM_TCLR_BIT];
            slow_q <= pwdata[LITM_SLOW_BIT];
        end
    end

    // Cause bits: events and forced bits set, a write of one or a read clears; set wins.
    always_comb begin
        cause_d = cause_q;
        if (wr_cause) begin
            cause_d = cause_d & ~wsrc;
        end
        if (rd_cause) begin
            cause_d = LITM_ZERO32;
        end
        if (wr_force) begin
            cause_d = cause_d | wsrc;
        end
        cause_d = (cause_d | cause_event) & LITM_SRC_MASK;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_q <= LITM_ZERO32;
        end else if (clk_en) begin
            cause_q <= cause_d;
        end
    end

    // Enable bits: write one to set, write one to the clear register to clear.
    always_comb begin
        enable_d = enable_q;
        if (wr_enclr) begin
            enable_d = enable_d & ~wsrc;
        end
        if (wr_enset) begin
            enable_d = enable_d | wsrc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= LITM_ZERO32;
        end else if (clk_en) begin
            enable_q <= enable_d;
        end
    end

    // An all-ones enable write restarts the timers when the option is on.
    assign timer_restart = wr_enset && tclr_en_q && pwdata == LITM_ALL_ONES;

    // -----------------------------------------------------------------------
    // Pacing
    // -----------------------------------------------------------------------
    logic pending;
    logic unit_tick;
    logic [15:0] gap_cnt_q;
    logic fire;
    assign pending = |(cause_q & enable_q);

    litm_tick #(
        .UNIT_CYC(LITM_UNIT_CYC)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .restart(fire || timer_restart),
        .slow(slow_q),
        .tick(unit_tick)
    );

    // Fire when pending with the interrupt low and the gap has run out or is zero.
    assign fire = pending && !irq && (gap_q == 16'h0000 || gap_cnt_q == 16'h0000);

    // Gap counter reloads at each assertion and counts units down.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt_q <= 16'h0000;
        end else if (clk_en) begin
            if (fire || timer_restart) begin
                gap_cnt_q <= gap_q;
            end else if (unit_tick && gap_cnt_q != 16'h0000) begin
                gap_cnt_q <= gap_cnt_q - 16'h0001;
            end
        end
    end

    // Interrupt rises on a fire and drops once no enabled cause remains.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            if (fire) begin
                irq <= 1'b1;
            end else if (!pending) begin
                irq <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Read data and response
    // -----------------------------------------------------------------------
    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = LITM_ZERO32;
        unique case (paddr)
            LITM_PACING_OFF: rdata_d = {16'h0000, gap_q};
            LITM_CAUSE_OFF: rdata_d = cause_q | {pending, 31'h0};
            LITM_ENSET_OFF: rdata_d = enable_q;
            LITM_EXTCTL_OFF: rdata_d = {30'h0, slow_q, tclr_en_q};
            default: rdata_d = LITM_ZERO32;
        endcase
    end

    // One wait state: ready the cycle after the access phase opens.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= LITM_ZERO32;
        end else if (clk_en) begin
            pready <= acc;
            pslverr <= acc && !hit;
            if (rd) begin
                prdata <= rdata_d;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------------
    a_zero_gap_fast: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && pending && !irq && gap_q == 16'h0000 |=> irq)
        else $error("Zero gap did not pass interrupt at once.");
    a_gap_reload: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && fire |=> gap_cnt_q == $past(gap_q))
        else $error("Gap counter did not reload on assertion.");
    a_no_early_irq: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && gap_q != 16'h0000 && gap_cnt_q != 16'h0000 |=> !$rose(irq))
        else $error("Interrupt reasserted too early.");
    a_force_sets: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr_force |=> (cause_q & $past(wsrc)) == $past(wsrc))
        else $error("Forced cause bit not set.");
    a_enset_sets: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr_enset |=> (enable_q & $past(wsrc)) == $past(wsrc))
        else $error("Enable bit not set.");
    a_enclr_clears: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr_enclr && !wr_enset |=> (enable_q & $past(wsrc)) == 32'h0000_0000)
        else $error("Enable bit not cleared.");
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ((cause_q | enable_q) & ~LITM_SRC_MASK) == 32'h0000_0000)
        else $error("Reserved bit set.");
    a_irq_needs_src: assert property (@(posedge pclk) disable iff (!presetn)
        irq && clk_en |-> pending || $past(pending))
        else $error("Interrupt without enabled cause.");
    a_restart_timer: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && timer_restart |=> gap_cnt_q == $past(gap_q))
        else $error("Timers not restarted on all-ones enable.");
    c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_paced: cover property (@(posedge pclk) disable iff (!presetn)
        pending && !irq && gap_cnt_q != 16'h0000);
    c_slow_tick: cover property (@(posedge pclk) disable iff (!presetn) unit_tick && slow_q);
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule : litm_top

// File: tb/litm_host_model.sv
// Host side model that receives the paced interrupt and measures its spacing.
`timescale 1ns/1ps
module litm_host_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Interrupt line and measurement restart.
    input wire logic irq,
    input wire logic clr,
    // Shortest spacing seen between two interrupt rises, in cycles.
    output int min_gap
);
    int cnt_q;
    logic irq_q;
    logic seen_q;
    // The first rise after a restart only starts the count, so a stale gap is never kept.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            min_gap <= 32'h7fff_ffff;
            cnt_q <= 0;
            irq_q <= 1'b0;
            seen_q <= 1'b0;
        end else if (clr) begin
            min_gap <= 32'h7fff_ffff;
            seen_q <= 1'b0;
            irq_q <= irq;
        end else begin
            irq_q <= irq;
            cnt_q <= cnt_q + 1;
            if (irq && !irq_q) begin
                if (seen_q && cnt_q < min_gap) begin
                    min_gap <= cnt_q;
                end
                seen_q <= 1'b1;
                cnt_q <= 1;
            end
        end
    end
endmodule : litm_host_model

// File: tb/testbench.sv
// Self-checking testbench of the interrupt pacing and enable block.
`timescale 1ns/1ps
module testbench
    import litm_pkg::*;
;
    logic pclk, presetn, clk_en, psel, penable, pwrite, irq, pready, pslverr, host_clr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, cause_event, rd, rnd, a, b;
    logic [3:0] pstrb;
    logic er;
    int n_errors, total_checks, cyc, min_gap, w;
    // ------------------------------------------------------------------
    // Design, host model and clock
    // ------------------------------------------------------------------
    litm_top u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cause_event(cause_event),
        .irq(irq));
    litm_host_model u_host (.pclk(pclk), .presetn(presetn), .irq(irq), .clr(host_clr),
        .min_gap(min_gap));
    // Free running clock of 40 ns.
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Cuts a hang short.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            end_sim();
        end
    end
    // ------------------------------------------------------------------
    // Tasks and expectation functions
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Cause read value with every valid source enabled: bits plus the summary.
    function automatic logic [31:0] exp_cause(input logic [31:0] v);
        return (v & LITM_SRC_MASK) | (((v & LITM_SRC_MASK) != 0) ? 32'h8000_0000 : 32'h0);
    endfunction : exp_cause
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the cycle watchdog ends a wait that never sees pready.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic fire(input logic [31:0] m);
        @(posedge pclk);
        cause_event <= m;
        @(posedge pclk);
        cause_event <= 32'h0;
    endtask : fire
    task automatic wait_irq();
        w = 0;
        do begin
            @(posedge pclk);
            w++;
        end while (irq !== 1'b1 && w < 1000);
    endtask : wait_irq
    // Four paced interrupts; each is cleared by a cause read before the next event.
    task automatic pace(input logic [15:0] g, input logic slow);
        apb(1'b1, LITM_EXTCTL_OFF, {30'h0, slow, 1'b0});
        apb(1'b1, LITM_PACING_OFF, {16'h0, g});
        host_clr <= 1'b1;
        @(posedge pclk);
        host_clr <= 1'b0;
        repeat (4) begin
            fire(32'h1);
            wait_irq();
            chk({31'h0, irq}, 32'h1);
            if (g == 0) chk(32'(w <= 3), 32'h1);
            apb(1'b0, LITM_CAUSE_OFF, 32'h0);
        end
        if (g != 0) chk(32'(min_gap >= g * LITM_UNIT_CYC * (slow ? LITM_SLOW_FACTOR : 1)), 32'h1);
        $display("pacing run gap %0d slow %0d done", g, slow);
    endtask : pace
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, host_clr, n_errors, total_checks, cyc} = '0;
        paddr = 12'h0;
        pwdata = 32'h0;
        cause_event = 32'h0;
        pstrb = 4'hf;
        clk_en = 1'b1;
        presetn = 1'b0;
        rnd = 32'h15ec;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, LITM_PACING_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, LITM_ENSET_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, LITM_PACING_OFF, 32'habcd_1234);
        apb(1'b0, LITM_PACING_OFF, 32'h0);
        chk(rd, 32'h0000_1234);
        // Only byte one of the gap is written when its strobe alone is set.
        pstrb <= 4'h2;
        apb(1'b1, LITM_PACING_OFF, LITM_ALL_ONES);
        pstrb <= 4'hf;
        apb(1'b0, LITM_PACING_OFF, 32'h0);
        chk(rd, 32'h0000_ff34);
        $display("reset and pacing register test done");
        repeat (4) begin
            rnd = lfsr(rnd);
            a = rnd;
            rnd = lfsr(rnd);
            b = rnd;
            apb(1'b1, LITM_ENSET_OFF, a);
            apb(1'b1, LITM_ENSET_OFF, b);
            apb(1'b0, LITM_ENSET_OFF, 32'h0);
            chk(rd, (a | b) & LITM_SRC_MASK);
            apb(1'b1, LITM_ENCLR_OFF, a);
            apb(1'b0, LITM_ENSET_OFF, 32'h0);
            chk(rd, b & ~a & LITM_SRC_MASK);
            apb(1'b1, LITM_ENCLR_OFF, LITM_ALL_ONES);
        end
        $display("enable set and clear test done");
        apb(1'b1, LITM_PACING_OFF, 32'h0);
        apb(1'b1, LITM_ENSET_OFF, LITM_SRC_MASK);
        for (int i = 0; i < 32; i++) begin
            apb(1'b1, LITM_FORCE_OFF, 32'h1 << i);
            repeat (3) @(posedge pclk);
            chk({31'h0, irq}, {31'h0, LITM_SRC_MASK[i]});
            apb(1'b0, LITM_CAUSE_OFF, 32'h0);
            chk(rd, exp_cause(32'h1 << i));
            repeat (3) @(posedge pclk);
            chk({31'h0, irq}, 32'h0);
        end
        repeat (6) begin
            rnd = lfsr(rnd);
            fire(rnd);
            repeat (3) @(posedge pclk);
            chk({31'h0, irq}, {31'h0, |(rnd & LITM_SRC_MASK)});
            apb(1'b0, LITM_CAUSE_OFF, 32'h0);
            chk(rd, exp_cause(rnd));
        end
        $display("cause bit test done");
        apb(1'b1, LITM_ENCLR_OFF, LITM_ALL_ONES);
        apb(1'b1, LITM_FORCE_OFF, 32'h0000_0004);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, LITM_ENSET_OFF, 32'h0000_0004);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, LITM_CAUSE_OFF, 32'h0);
        chk(rd, 32'h8000_0004);
        apb(1'b1, LITM_ENSET_OFF, 32'h0000_0001);
        // Writing one to a cause bit clears only that bit.
        apb(1'b1, LITM_FORCE_OFF, 32'h0000_0005);
        apb(1'b1, LITM_CAUSE_OFF, 32'h0000_0001);
        apb(1'b0, LITM_CAUSE_OFF, 32'h0);
        chk(rd, 32'h8000_0004);
        // An event while the clock enable is low is not taken.
        clk_en <= 1'b0;
        fire(32'h0000_0004);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        clk_en <= 1'b1;
        $display("enable gating test done");
        pace(16'h0000, 1'b0);
        pace(16'h0003, 1'b0);
        pace(16'h0003, 1'b1);
        // An all-ones enable write late in a gap restarts the gap, so the next
        // interrupt comes a full gap after the write instead of at the old expiry.
        apb(1'b1, LITM_EXTCTL_OFF, 32'h0000_0001);
        apb(1'b1, LITM_PACING_OFF, 32'h0000_0003);
        host_clr <= 1'b1;
        @(posedge pclk);
        host_clr <= 1'b0;
        fire(32'h1);
        wait_irq();
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, LITM_CAUSE_OFF, 32'h0);
        repeat (12) @(posedge pclk);
        apb(1'b1, LITM_ENSET_OFF, LITM_ALL_ONES);
        fire(32'h1);
        wait_irq();
        chk({31'h0, irq}, 32'h1);
        chk(32'(min_gap > 3 * LITM_UNIT_CYC + 12), 32'h1);
        apb(1'b0, LITM_ENSET_OFF, 32'h0);
        chk(rd, LITM_SRC_MASK);
        $display("timer restart test done");
        end_sim();
    end
endmodule : testbench
